// ---- verilog/pecint_pkg.sv ----
// pecint_pkg: constants and types for the port edge change interrupt block
// assumes a 32-bit classic wishbone register bus and a six-pin port
package pecint_pkg;

    // port and register geometry
    localparam int PECINT_PINS = 6;
    localparam int PECINT_REG_W = 8;
    localparam int PECINT_DATA_W = 32;
    localparam int PECINT_ADDR_W = 8;

    // register byte offsets
    localparam logic [PECINT_ADDR_W-1:0] PECINT_OFS_RISE = 8'h00;
    localparam logic [PECINT_ADDR_W-1:0] PECINT_OFS_FALL = 8'h04;
    localparam logic [PECINT_ADDR_W-1:0] PECINT_OFS_FLAG = 8'h08;
    localparam logic [PECINT_ADDR_W-1:0] PECINT_OFS_MASK = 8'h0c;
    localparam logic [PECINT_ADDR_W-1:0] PECINT_OFS_PINS = 8'h10;

    // reset values
    localparam logic [PECINT_PINS-1:0] PECINT_RST_RISE = 6'h00;
    localparam logic [PECINT_PINS-1:0] PECINT_RST_FALL = 6'h00;
    localparam logic [PECINT_PINS-1:0] PECINT_RST_FLAG = 6'h00;
    localparam logic [PECINT_PINS-1:0] PECINT_RST_MASK = 6'h00;
    localparam logic [PECINT_PINS-1:0] PECINT_RST_PIN = 6'h00;

    // bus request carried as one unit
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [PECINT_ADDR_W-1:0] adr;
        logic [3:0] sel;
        logic [PECINT_DATA_W-1:0] dat;
    } pecint_wb_req_t;

    // bus answer carried as one unit
    typedef struct packed {
        logic ack;
        logic err;
        logic [PECINT_DATA_W-1:0] dat;
    } pecint_wb_rsp_t;

    // register select decode
    typedef enum logic [2:0] {
        PECINT_SEL_NONE,
        PECINT_SEL_RISE,
        PECINT_SEL_FALL,
        PECINT_SEL_FLAG,
        PECINT_SEL_MASK,
        PECINT_SEL_PINS
    } pecint_sel_t;

endpackage

// ---- verilog/pecint_top.sv ----
// pecint_top: edge change detection and flags for a six-pin port
// assumes pins may be asynchronous; two-stage sync to sys_clk_in; wishbone classic slave
// assumes software clears flags by writing ones
//
// Local design decisions: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
module pecint_top
    import pecint_pkg::*;
#(
    parameter int PINS = PECINT_PINS
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [PINS-1:0] port_pin_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [PECINT_ADDR_W-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [PECINT_DATA_W-1:0] wb_dat_in,
    output logic [PECINT_DATA_W-1:0] wb_dat_out,
    output logic wb_ack_out,
    output logic wb_err_out,
    output logic irq_out
);

    pecint_wb_req_t req;
    pecint_wb_rsp_t rsp;
    pecint_wb_rsp_t next_rsp;
    pecint_sel_t sel;

    logic [PINS-1:0] pin_sync;
    logic [PINS-1:0] pin_now;
    logic [PINS-1:0] pin_prev;
    logic [PINS-1:0] next_pin_sync;
    logic [PINS-1:0] next_pin_now;
    logic [PINS-1:0] next_pin_prev;

    logic [PINS-1:0] rising_edge_enable;
    logic [PINS-1:0] falling_edge_enable;
    logic [PINS-1:0] change_flags;
    logic [PINS-1:0] irq_mask;
    logic [PINS-1:0] next_rising_edge_enable;
    logic [PINS-1:0] next_falling_edge_enable;
    logic [PINS-1:0] next_change_flags;
    logic [PINS-1:0] next_irq_mask;
    logic next_irq;
    logic irq;

    logic [PINS-1:0] rise_seen;
    logic [PINS-1:0] fall_seen;
    logic [PINS-1:0] hit;
    logic access;
    logic wr_low;
    logic wr_rise;
    logic wr_fall;
    logic wr_flag;
    logic wr_mask;
    logic [PINS-1:0] wr_bits;
    logic [PINS-1:0] flag_clear;

    // implemented bits in the low lane, upper bits zero
    function automatic logic [PECINT_DATA_W-1:0] widen(input logic [PINS-1:0] v);
        logic [PECINT_DATA_W-1:0] r;
        r = '0;
        r[PINS-1:0] = v;
        return r;
    endfunction

    // only the implemented low bits are stored
    function automatic logic [PINS-1:0] lane_bits(input logic [PECINT_DATA_W-1:0] w);
        return w[PINS-1:0];
    endfunction

    function automatic logic [PINS-1:0] armed_edge(
        input logic [PINS-1:0] now_v,
        input logic [PINS-1:0] prev_v,
        input logic [PINS-1:0] armed
    );
        return now_v & ~prev_v & armed;
    endfunction

    // write strobe for one register
    function automatic logic is_write(
        input logic wr,
        input pecint_sel_t cur,
        input pecint_sel_t target
    );
        return wr && (cur == target);
    endfunction

    // set wins over a clear in the same cycle
    function automatic logic [PINS-1:0] flag_update(
        input logic [PINS-1:0] flags,
        input logic [PINS-1:0] clear,
        input logic [PINS-1:0] set
    );
        logic [PINS-1:0] kept;
        kept = flags & ~clear;
        return kept | set;
    endfunction

    function automatic pecint_sel_t decode(input logic [PECINT_ADDR_W-1:0] a);
        pecint_sel_t s;
        s = PECINT_SEL_NONE;
        if (a == PECINT_OFS_RISE) begin
            s = PECINT_SEL_RISE;
        end else if (a == PECINT_OFS_FALL) begin
            s = PECINT_SEL_FALL;
        end else if (a == PECINT_OFS_FLAG) begin
            s = PECINT_SEL_FLAG;
        end else if (a == PECINT_OFS_MASK) begin
            s = PECINT_SEL_MASK;
        end else if (a == PECINT_OFS_PINS) begin
            s = PECINT_SEL_PINS;
        end
        return s;
    endfunction

    always_comb begin
        req.cyc = wb_cyc_in;
        req.stb = wb_stb_in;
        req.we = wb_we_in;
        req.adr = wb_adr_in;
        req.sel = wb_sel_in;
        req.dat = wb_dat_in;
    end

    // pin sampling
    always_comb begin
        next_pin_sync = port_pin_in;
        next_pin_now = pin_sync;
        next_pin_prev = pin_now;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            pin_sync <= PECINT_RST_PIN;
            pin_now <= PECINT_RST_PIN;
            pin_prev <= PECINT_RST_PIN;
        end else begin
            pin_sync <= next_pin_sync;
            pin_now <= next_pin_now;
            pin_prev <= next_pin_prev;
        end
    end

    // edge qualification
    always_comb begin
        rise_seen = armed_edge(pin_now, pin_prev, rising_edge_enable);
        fall_seen = armed_edge(~pin_now, ~pin_prev, falling_edge_enable);
        hit = rise_seen | fall_seen;
    end

    // bus decode
    always_comb begin
        sel = decode(req.adr);
        access = req.cyc && req.stb && !rsp.ack && !rsp.err;
        wr_low = access && req.we && req.sel[0];
        wr_rise = is_write(wr_low, sel, PECINT_SEL_RISE);
        wr_fall = is_write(wr_low, sel, PECINT_SEL_FALL);
        wr_flag = is_write(wr_low, sel, PECINT_SEL_FLAG);
        wr_mask = is_write(wr_low, sel, PECINT_SEL_MASK);
        wr_bits = lane_bits(req.dat);
    end

    // edge enable registers
    always_comb begin
        next_rising_edge_enable = rising_edge_enable;
        next_falling_edge_enable = falling_edge_enable;
        if (wr_rise) begin
            next_rising_edge_enable = wr_bits;
        end
        if (wr_fall) begin
            next_falling_edge_enable = wr_bits;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            rising_edge_enable <= PECINT_RST_RISE;
            falling_edge_enable <= PECINT_RST_FALL;
        end else begin
            rising_edge_enable <= next_rising_edge_enable;
            falling_edge_enable <= next_falling_edge_enable;
        end
    end

    // interrupt mask register
    always_comb begin
        next_irq_mask = irq_mask;
        if (wr_mask) begin
            next_irq_mask = wr_bits;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            irq_mask <= PECINT_RST_MASK;
        end else begin
            irq_mask <= next_irq_mask;
        end
    end

    // change flags
    always_comb begin
        flag_clear = '0;
        if (wr_flag) begin
            flag_clear = wr_bits;
        end
        next_change_flags = flag_update(change_flags, flag_clear, hit);
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            change_flags <= PECINT_RST_FLAG;
        end else begin
            change_flags <= next_change_flags;
        end
    end

    always_comb begin
        next_irq = |(next_change_flags & next_irq_mask);
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    // bus answer
    always_comb begin
        next_rsp.ack = 1'b0;
        next_rsp.err = 1'b0;
        next_rsp.dat = '0;
        if (access) begin
            unique case (sel)
                PECINT_SEL_RISE: begin
                    next_rsp.ack = 1'b1;
                    next_rsp.dat = widen(rising_edge_enable);
                end
                PECINT_SEL_FALL: begin
                    next_rsp.ack = 1'b1;
                    next_rsp.dat = widen(falling_edge_enable);
                end
                PECINT_SEL_FLAG: begin
                    next_rsp.ack = 1'b1;
                    next_rsp.dat = widen(change_flags);
                end
                PECINT_SEL_MASK: begin
                    next_rsp.ack = 1'b1;
                    next_rsp.dat = widen(irq_mask);
                end
                PECINT_SEL_PINS: begin
                    next_rsp.ack = 1'b1;
                    next_rsp.dat = widen(pin_now);
                end
                PECINT_SEL_NONE: begin
                    next_rsp.err = 1'b1;
                end
                default: begin
                    next_rsp.err = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            rsp <= '0;
        end else begin
            rsp <= next_rsp;
        end
    end

    always_comb begin
        wb_dat_out = rsp.dat;
        wb_ack_out = rsp.ack;
        wb_err_out = rsp.err;
        irq_out = irq;
    end

endmodule

// ---- test/pecint_sva.sv ----
// pecint_sva: bus and flag checks on pecint_top ports
// assumes bound to every pecint_top instance
`timescale 1ns/100ps
module pecint_sva
    import pecint_pkg::*;
#(
    parameter int PINS = PECINT_PINS
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [PINS-1:0] port_pin_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic [PECINT_ADDR_W-1:0] wb_adr_in,
    input wire logic [PECINT_DATA_W-1:0] wb_dat_out,
    input wire logic wb_ack_out,
    input wire logic wb_err_out,
    input wire logic irq_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    logic req;
    assign req = wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out;
    a_answer_next: assert property (req |=> wb_ack_out || wb_err_out)
        else $error("no bus answer");
    a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack too long");
    a_err_unmapped: assert property (req && wb_adr_in > 8'h10 |=> wb_err_out && !wb_ack_out)
        else $error("unmapped not refused");
    a_data_idle: assert property (!wb_ack_out |-> wb_dat_out == '0)
        else $error("read data outside ack");
    a_upper_zero: assert property (wb_dat_out[PECINT_DATA_W-1:PINS] == '0)
        else $error("upper bits set");
    a_reset_quiet: assert property (disable iff (1'b0) !reset_n_in |=> !irq_out && !wb_ack_out)
        else $error("outputs live after reset");
    a_irq_hold: assert property (irq_out && !wb_cyc_in |=> irq_out)
        else $error("irq dropped without write");
    a_irq_cause: assert property ($rose(irq_out) && !$past(wb_cyc_in) |-> $past(port_pin_in, 3) != $past(port_pin_in, 4))
        else $error("irq without pin edge");
endmodule
bind pecint_top pecint_sva #(.PINS(PINS)) pecint_sva_i (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .port_pin_in(port_pin_in),
    .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in),
    .wb_adr_in(wb_adr_in),
    .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out),
    .wb_err_out(wb_err_out),
    .irq_out(irq_out)
);

// ---- test/pecint_pins.sv ----
// pecint_pins: outside circuitry driving the port pins
// assumes the bench names the wanted level
`timescale 1ns/100ps
module pecint_pins (
    input wire logic clk_in,
    input wire logic [5:0] want_in,
    output logic [5:0] pin_out = 6'h00
);
    // levels change after an edge and hold whole cycles
    always @(posedge clk_in) begin
        pin_out <= want_in;
    end
endmodule

// ---- test/test_port_edge_change_interrupt.sv ----
// bench for pecint_top: register tasks over classic wishbone
// assumes pecint_pins drives the port pins
`timescale 1ns/100ps
module test_port_edge_change_interrupt;
    import pecint_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, cs = 1'b0, we = 1'b0;
    logic ack, err, irq, e;
    logic [7:0] adr = 8'h00;
    logic [3:0] be = 4'hf;
    logic [31:0] wd = 32'h0, rd, q;
    logic [5:0] want = 6'h00, pins;
    int bad_count = 0, checks_done = 0, cycles = 0;
    pecint_pins pecint_pins_i (.clk_in(clk), .want_in(want), .pin_out(pins));
    pecint_top pecint_top_i (.sys_clk_in(clk), .reset_n_in(rst_n), .port_pin_in(pins),
        .wb_cyc_in(cs), .wb_stb_in(cs), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(be),
        .wb_dat_in(wd), .wb_dat_out(rd), .wb_ack_out(ack), .wb_err_out(err), .irq_out(irq));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            complete_run();
        end
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        cs <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1 && err !== 1'b1);
        q = rd;
        e = err;
        cs <= 1'b0;
        @(posedge clk);
    endtask
    task automatic reset_check(input int last);
        for (int i = 0; i <= last; i++) begin
            bus(1'b0, 8'(4 * i), 32'h0);
            chk("reset value", q, 32'h0);
        end
        chk("irq after reset", {31'h0, irq}, 32'h0);
        $display("reset test done");
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        reset_check(4);
        bus(1'b1, PECINT_OFS_RISE, 32'hffffffff);
        bus(1'b0, PECINT_OFS_RISE, 32'h0);
        chk("rise upper bits", q, 32'h3f);
        bus(1'b1, PECINT_OFS_MASK, 32'h3f);
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, PECINT_OFS_RISE, k ? 32'h0 : 32'hff);
            bus(1'b1, PECINT_OFS_FALL, k ? 32'hff : 32'h0);
            want <= k ? 6'h00 : 6'h15;
            repeat (6) @(posedge clk);
            chk("irq raised", {31'h0, irq}, 32'h1);
            bus(1'b0, PECINT_OFS_FLAG, 32'h0);
            chk("edge flags", q, 32'h15);
            bus(1'b1, PECINT_OFS_FLAG, 32'h1);
            bus(1'b0, PECINT_OFS_FLAG, 32'h0);
            chk("one flag cleared", q, 32'h14);
            bus(1'b1, PECINT_OFS_FLAG, 32'h14);
            chk("irq cleared", {31'h0, irq}, 32'h0);
            $display("edge test %0d done", k);
        end
        bus(1'b1, PECINT_OFS_FALL, 32'h0);
        want <= 6'h2a;
        repeat (6) @(posedge clk);
        want <= 6'h00;
        repeat (6) @(posedge clk);
        bus(1'b0, PECINT_OFS_FLAG, 32'h0);
        chk("no flag unarmed", q, 32'h0);
        bus(1'b0, 8'h20, 32'h0);
        chk("unmapped error", {31'h0, e}, 32'h1);
        $display("unarmed test done");
        be <= 4'he;
        bus(1'b1, PECINT_OFS_MASK, 32'h0);
        be <= 4'hf;
        bus(1'b0, PECINT_OFS_MASK, 32'h0);
        chk("lane write ignored", q, 32'h3f);
        bus(1'b1, PECINT_OFS_RISE, 32'h3f);
        want <= 6'h3f;
        repeat (6) @(posedge clk);
        bus(1'b0, PECINT_OFS_PINS, 32'h0);
        chk("pin state", q, 32'h3f);
        chk("irq before reset", {31'h0, irq}, 32'h1);
        bus(1'b1, PECINT_OFS_MASK, 32'h0);
        chk("irq masked", {31'h0, irq}, 32'h0);
        bus(1'b1, PECINT_OFS_MASK, 32'h3f);
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        $display("mask test done");
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        reset_check(3);
        complete_run();
    end
endmodule
